//--- interrupt_select_and_accept_tb.sv
`timescale 1ns/100ps
`include "isa_params.svh"

module interrupt_select_and_accept_tb
    import isa_pkg::*;
;
    logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [15:4] periph_irq;
    logic [9:0] src;
    logic nmi_irq, instr_last, return_maskable, return_nonmaskable;
    logic [15:0] cpu_pc, cpu_sp, sp, pc, pc_seen, sp_seen;
    logic [6:0] cpu_status, status_word, st, st_seen;
    logic [7:0] mem_rdata;
    logic status_load, master_irq_enable, seq_busy, errv;
    isa_mem_t mem_out;
    isa_load_t pc_out, sp_out;
    int n_errors, checks, cyc, n_pc, pc0;
    int sb[5] = '{7, 3, 2, 1, 0};
    int lb[5] = '{8, 12, 13, 14, 15};

    isa_core dut_u (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .periph_irq, .nmi_irq,
        .serial_rx_a_irq(src[0]), .sync_serial_irq(src[1]),
        .output_compare_irq(src[2]), .ext_irq_two(src[3]),
        .ext_irq_three(src[4]), .serial_rx_b_irq(src[5]),
        .ext_irq_four(src[6]), .serial_tx_b_irq(src[7]),
        .timer_counter_irq(src[8]), .ext_irq_five(src[9]), .instr_last,
        .return_maskable, .return_nonmaskable, .cpu_pc, .cpu_sp,
        .cpu_status, .mem_rdata, .mem_out, .pc_out, .sp_out, .status_load,
        .status_word, .master_irq_enable, .seq_busy);
    isa_cpu_mem mem_u (.core_clk, .mem_out, .mem_rdata);

    initial
    begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [15:0] vec(input int i);
        return {8'h80 + 8'(i), 8'(i << 4)};
    endfunction

    task automatic end_of_test();
        $display("counts: %0d checks, %0d mismatches", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge core_clk);
    endtask

    // Long settle covers the pin synchronisers
    task automatic fire(input logic [11:0] p, input logic n,
        input logic [9:0] s);
        periph_irq <= p;
        nmi_irq <= n;
        src <= s;
        @(posedge core_clk);
        periph_irq <= '0;
        nmi_irq <= 0;
        src <= '0;
        repeat (5) @(posedge core_clk);
    endtask

    task automatic step(input logic rm, input logic rn);
        return_maskable <= rm;
        return_nonmaskable <= rn;
        instr_last <= 1;
        @(posedge core_clk);
        instr_last <= 0;
        return_maskable <= 0;
        return_nonmaskable <= 0;
        repeat (2) @(posedge core_clk);
        while (seq_busy !== 1'b0)
            @(posedge core_clk);
        @(posedge core_clk);
    endtask

    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (pc_out.load === 1'b1)
        begin
            pc_seen <= pc_out.value;
            n_pc <= n_pc + 1;
        end
        if (sp_out.load === 1'b1)
            sp_seen <= sp_out.value;
        if (status_load === 1'b1)
            st_seen <= status_word;
        if (cyc == 5000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, periph_irq, src} = '0;
        {nmi_irq, instr_last, return_maskable, return_nonmaskable} = '0;
        {cpu_pc, cpu_sp, cpu_status} = '0;
        sys_rst = 1;
        void'($urandom(32'h1491));
        repeat (16) @(posedge core_clk);
        sys_rst <= 0;
        @(posedge core_clk);
        apb(0, `ISA_ADDR_SELECT, 0);
        chk("select reset", 32'h0, rdv);
        apb(0, `ISA_ADDR_LATCH, 0);
        chk("latch reset", 32'h0, rdv);
        apb(0, 12'h004, 0);
        chk("unmapped error", 32'h1, errv);
        v_sel: begin
            logic [7:0] v;
            v = $urandom;
            apb(1, `ISA_ADDR_SELECT, v);
            apb(0, `ISA_ADDR_SELECT, 0);
            chk("select rw", v & `ISA_SELECT_MASK, rdv);
        end
        $display("test registers done");
        for (int k = 0; k < 5; k++)
            for (int s = 0; s < 2; s++)
            begin
                apb(1, `ISA_ADDR_SELECT, 32'(s) << sb[k]);
                fire(0, 0, 10'h1 << (2 * k + 1 - s));
                apb(0, `ISA_ADDR_LATCH, 0);
                chk("unselected", 32'h0, rdv);
                fire(0, 0, 10'h1 << (2 * k + s));
                apb(1, `ISA_ADDR_LATCH, 32'hffff);
                apb(0, `ISA_ADDR_LATCH, 0);
                chk("selected", 32'h1 << lb[k], rdv);
                apb(1, `ISA_ADDR_LATCH, 0);
                apb(0, `ISA_ADDR_LATCH, 0);
                chk("cleared", 32'h0, rdv);
            end
        $display("test source select done");
        sp = 16'h0400 + 16'($urandom_range(0, 255));
        pc = $urandom;
        st = $urandom;
        cpu_sp <= sp;
        cpu_pc <= pc;
        cpu_status <= st;
        apb(1, `ISA_ADDR_ENABLE, 32'h0441);
        fire(12'h044, 0, 0);
        step(0, 0);
        chk("vector", vec(6), pc_seen);
        chk("new sp", sp - 16'd3, sp_seen);
        chk("psw", {st, 1'b1}, mem_u.mem[sp]);
        chk("pc high", pc[15:8], mem_u.mem[sp - 16'd1]);
        chk("pc low", pc[7:0], mem_u.mem[sp - 16'd2]);
        apb(0, `ISA_ADDR_ENABLE, 0);
        chk("master", 32'h0, rdv[0]);
        apb(0, `ISA_ADDR_LATCH, 0);
        chk("latch left", 32'h400, rdv);
        $display("test accept done");
        cpu_sp <= sp - 16'd3;
        // maskable service ends with its own return
        step(1, 0);
        chk("ret pc", pc, pc_seen);
        chk("ret status", st, st_seen);
        chk("ret sp", sp, sp_seen);
        step(0, 0);
        chk("next vector", vec(10), pc_seen);
        $display("test return done");
        pc0 = n_pc;
        apb(1, `ISA_ADDR_ENABLE, 32'h0010);
        fire(12'h001, 0, 0);
        step(0, 0);
        chk("blocked", pc0, n_pc);
        fire(0, 1, 0);
        step(0, 0);
        chk("nmi vector", vec(3), pc_seen);
        cpu_sp <= sp - 16'd6;
        // non-maskable service ends with its own return
        step(0, 1);
        chk("nmi ret pc", pc, pc_seen);
        apb(0, `ISA_ADDR_ENABLE, 0);
        chk("master kept", 32'h0, rdv[0]);
        $display("test masking done");
        end_of_test();
    end
endmodule

//--- isa_core.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "isa_params.svh"

module isa_core
    import isa_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:4] periph_irq,
    input wire logic nmi_irq,
    input wire logic serial_rx_a_irq,
    input wire logic sync_serial_irq,
    input wire logic output_compare_irq,
    input wire logic serial_rx_b_irq,
    input wire logic serial_tx_b_irq,
    input wire logic timer_counter_irq,
    input wire logic ext_irq_two,
    input wire logic ext_irq_three,
    input wire logic ext_irq_four,
    input wire logic ext_irq_five,
    input wire logic instr_last,
    input wire logic return_maskable,
    input wire logic return_nonmaskable,
    input wire logic [15:0] cpu_pc,
    input wire logic [15:0] cpu_sp,
    input wire logic [6:0] cpu_status,
    input wire logic [7:0] mem_rdata,
    output isa_mem_t mem_out,
    output isa_load_t pc_out,
    output isa_load_t sp_out,
    output logic status_load,
    output logic [6:0] status_word,
    output logic master_irq_enable,
    output logic seq_busy
);

    function automatic logic [3:0] isa_first(input logic [15:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 15; i >= 0; i--)
        begin
            if (v[i])
            begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic isa_hit(input logic [11:0] a,
                                     input logic [11:0] target);
        return a == target;
    endfunction

    isa_state_t state_q;
    logic [2:0] step_q;
    logic [7:0] source_select_reg_q;
    logic [15:0] request_latch_q;
    logic [15:4] source_enable_flag_q;
    logic master_irq_enable_q;
    logic [3:0] win_q;
    logic [15:0] sp_q;
    logic [15:0] pc_q;
    logic [7:0] lo_q;
    // Enable as it stood before the take edge cleared it
    logic saved_en_q;
    logic [3:0] ext_meta_q;
    logic [3:0] ext_sync_q;
    logic [3:0] ext_prev_q;
    logic [3:0] ext_rise;
    logic [15:0] req_set;
    logic [15:0] maskable_ready;
    logic [15:0] pending;
    logic take;
    logic bus_wr;
    logic bus_ok;
    logic [31:0] bus_rd;

    // Pins cross into core_clk through two flops
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ext_meta_q <= 4'h0;
            ext_sync_q <= 4'h0;
            ext_prev_q <= 4'h0;
        end
        else
        begin
            ext_meta_q <= {ext_irq_five, ext_irq_four, ext_irq_three,
                           ext_irq_two};
            ext_sync_q <= ext_meta_q;
            ext_prev_q <= ext_sync_q;
        end
    end

    // Rising edge only; falling edges are never detected
    assign ext_rise = ext_sync_q & ~ext_prev_q;

    always_comb
    begin
        req_set = 16'h0000;
        req_set[15:4] = periph_irq;
        req_set[`ISA_BIT_NMI] = nmi_irq;
        // R03 level 9 source
        req_set[8] = source_select_reg_q[`ISA_SEL_LEVEL9] ?
                     sync_serial_irq : serial_rx_a_irq;
        // R04 level 13 source
        req_set[12] = source_select_reg_q[`ISA_SEL_LEVEL13] ?
                      ext_rise[0] : output_compare_irq;
        // R05 level 14 source
        req_set[13] = source_select_reg_q[`ISA_SEL_LEVEL14] ?
                      serial_rx_b_irq : ext_rise[1];
        // R06 level 15 source
        req_set[14] = source_select_reg_q[`ISA_SEL_LEVEL15] ?
                      serial_tx_b_irq : ext_rise[2];
        // R07 level 16 source
        req_set[15] = source_select_reg_q[`ISA_SEL_LEVEL16] ?
                      ext_rise[3] : timer_counter_irq;
    end
    // R01 R02 unselected source never reaches a latch
    // (the mux above is the only path into req_set)

    // R16 R22 master enable gates all maskable levels
    assign maskable_ready = {request_latch_q[15:4] & source_enable_flag_q,
                             4'h0} & {16{master_irq_enable_q}};
    // R24 non-maskable bypasses both enables
    assign pending = maskable_ready |
                     (request_latch_q & (16'h1 << `ISA_BIT_NMI));
    // R20 R15 sample only in the instruction's last cycle
    assign take = (state_q == ISA_IDLE) && instr_last && (pending != 0);

    // APB: one wait state so every answer leaves a flop
    assign bus_wr = psel && penable && pready && pwrite;
    assign bus_ok = isa_hit(paddr, `ISA_ADDR_ENABLE) ||
                    isa_hit(paddr, `ISA_ADDR_LATCH) ||
                    isa_hit(paddr, `ISA_ADDR_SELECT) ||
                    isa_hit(paddr, `ISA_ADDR_STATUS);

    always_comb
    begin
        bus_rd = 32'h0000_0000;
        if (isa_hit(paddr, `ISA_ADDR_ENABLE))
        begin
            bus_rd[15:4] = source_enable_flag_q;
            bus_rd[`ISA_BIT_MASTER_EN] = master_irq_enable_q;
        end
        else if (isa_hit(paddr, `ISA_ADDR_LATCH))
        begin
            bus_rd[15:0] = request_latch_q;
        end
        else if (isa_hit(paddr, `ISA_ADDR_SELECT))
        begin
            bus_rd[7:0] = source_select_reg_q;
        end
        else if (isa_hit(paddr, `ISA_ADDR_STATUS))
        begin
            bus_rd[7:0] = {state_q, step_q, win_q[2:0]};
            bus_rd[8] = win_q[3];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !bus_ok;
            if (psel && penable && !pready && !pwrite)
            begin
                prdata <= bus_rd;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            source_select_reg_q <= `ISA_SELECT_RESET;
        end
        else if (bus_wr && isa_hit(paddr, `ISA_ADDR_SELECT))
        begin
            // R08 software sets this before sources run
            source_select_reg_q <= pwdata[7:0] & `ISA_SELECT_MASK;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            source_enable_flag_q <=
                12'(`ISA_ENABLE_RESET >> `ISA_FIRST_MASKABLE);
        end
        else if (bus_wr && isa_hit(paddr, `ISA_ADDR_ENABLE))
        begin
            source_enable_flag_q <= pwdata[15:4];
        end
    end

    // Sequencer owns the flag while busy; bus writes lose
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            master_irq_enable_q <= 1'b0;
        end
        // R11 acceptance clears enable first
        else if (take)
        begin
            master_irq_enable_q <= 1'b0;
        end
        // R18 enable restored from stacked status
        else if (state_q == ISA_RETURN && step_q == 3'd4)
        begin
            master_irq_enable_q <= mem_rdata[`ISA_BIT_MASTER_EN];
        end
        else if (state_q == ISA_IDLE && bus_wr &&
                 isa_hit(paddr, `ISA_ADDR_ENABLE))
        begin
            master_irq_enable_q <= pwdata[`ISA_BIT_MASTER_EN];
        end
    end

    // R09 held until accept, reset or write of 0; new set wins
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            request_latch_q <= `ISA_LATCH_RESET;
        end
        else
        begin
            for (int i = 0; i < 16; i++)
            begin
                if (req_set[i])
                begin
                    request_latch_q[i] <= 1'b1;
                end
                // R12 accepted source cleared
                else if (take && isa_first(pending) == 4'(i))
                begin
                    request_latch_q[i] <= 1'b0;
                end
                // R23 zero clears, one is ignored
                else if (bus_wr && isa_hit(paddr, `ISA_ADDR_LATCH) &&
                         !pwdata[i])
                begin
                    request_latch_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_q <= ISA_IDLE;
            step_q <= 3'd0;
            win_q <= 4'h0;
            sp_q <= 16'h0000;
            pc_q <= 16'h0000;
            saved_en_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                ISA_IDLE:
                begin
                    step_q <= 3'd0;
                    // R10 start only at instruction end
                    if (take)
                    begin
                        state_q <= ISA_ACCEPT;
                        // R25 lowest index is highest priority
                        win_q <= isa_first(pending);
                        sp_q <= cpu_sp;
                        pc_q <= cpu_pc;
                        saved_en_q <= master_irq_enable_q;
                    end
                    else if (instr_last &&
                             (return_maskable || return_nonmaskable))
                    begin
                        state_q <= ISA_RETURN;
                        sp_q <= cpu_sp;
                    end
                end
                ISA_ACCEPT:
                begin
                    step_q <= step_q + 3'd1;
                    // R10 seven cycles here, eight counting the take cycle
                    if (step_q == `ISA_ACCEPT_CYCLES - 3'd1)
                    begin
                        state_q <= ISA_IDLE;
                    end
                end
                ISA_RETURN:
                begin
                    step_q <= step_q + 3'd1;
                    if (step_q == `ISA_RETURN_CYCLES - 3'd1)
                    begin
                        state_q <= ISA_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ISA_IDLE;
                end
            endcase
        end
    end

    // Memory: read data is valid the cycle after the request
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            mem_out <= '0;
            lo_q <= 8'h00;
        end
        else
        begin
            mem_out <= '0;
            if (state_q == ISA_ACCEPT)
            begin
                // R13 R21 push status, PC high, PC low only
                unique case (step_q)
                    3'd0: mem_out <= '{1'b1, 1'b1, sp_q,
                                       {cpu_status, saved_en_q}};
                    3'd1: mem_out <= '{1'b1, 1'b1, sp_q - 16'd1,
                                       pc_q[15:8]};
                    // R19 PC low lands at new SP plus 1
                    3'd2: mem_out <= '{1'b1, 1'b1, sp_q - 16'd2,
                                       pc_q[7:0]};
                    // R14 fetch vector, low byte then high
                    3'd3: mem_out <= '{1'b1, 1'b0, `ISA_VECTOR_TOP -
                                       {11'h0, win_q, 1'b0}, 8'h00};
                    3'd4: mem_out <= '{1'b1, 1'b0, `ISA_VECTOR_TOP -
                                       {11'h0, win_q, 1'b0} + 16'd1, 8'h00};
                    default: mem_out <= '0;
                endcase
                // Low vector byte returns one cycle after its read
                if (step_q == 3'd5)
                begin
                    lo_q <= mem_rdata;
                end
            end
            else if (state_q == ISA_RETURN)
            begin
                // R18 pop PC low, PC high, then status
                unique case (step_q)
                    3'd0: mem_out <= '{1'b1, 1'b0, sp_q + 16'd1, 8'h00};
                    3'd1: mem_out <= '{1'b1, 1'b0, sp_q + 16'd2, 8'h00};
                    3'd2: mem_out <= '{1'b1, 1'b0, sp_q + 16'd3, 8'h00};
                    default: mem_out <= '0;
                endcase
                if (step_q == 3'd2)
                begin
                    lo_q <= mem_rdata;
                end
            end
        end
    end

    // PC high byte in return lands with pc load below
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            pc_out <= '0;
            sp_out <= '0;
            status_load <= 1'b0;
            status_word <= 7'h00;
        end
        else
        begin
            pc_out.load <= 1'b0;
            sp_out.load <= 1'b0;
            status_load <= 1'b0;
            if (state_q == ISA_ACCEPT && step_q == 3'd2)
            begin
                // R13 stack pointer down by three
                sp_out <= '{1'b1, sp_q - 16'd3};
            end
            if (state_q == ISA_ACCEPT && step_q == 3'd6)
            begin
                // R14 jump to entry address
                pc_out <= '{1'b1, {mem_rdata, lo_q}};
            end
            if (state_q == ISA_RETURN && step_q == 3'd3)
            begin
                // R18 return address restored
                pc_out <= '{1'b1, {mem_rdata, lo_q}};
            end
            if (state_q == ISA_RETURN && step_q == 3'd4)
            begin
                // R18 status and stack pointer restored
                status_load <= 1'b1;
                status_word <= mem_rdata[7:1];
                sp_out <= '{1'b1, sp_q + 16'd3};
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            master_irq_enable <= 1'b0;
            seq_busy <= 1'b0;
        end
        else
        begin
            master_irq_enable <= master_irq_enable_q;
            seq_busy <= take || (state_q != ISA_IDLE &&
                        !(step_q == `ISA_ACCEPT_CYCLES - 3'd1 &&
                          state_q == ISA_ACCEPT) &&
                        !(step_q == `ISA_RETURN_CYCLES - 3'd1 &&
                          state_q == ISA_RETURN)) ||
                        (state_q == ISA_IDLE && instr_last &&
                         (return_maskable || return_nonmaskable));
        end
    end

endmodule

//--- isa_core_props.sv
`timescale 1ns/100ps
`include "isa_params.svh"

module isa_core_props
    import isa_pkg::*;
(
    input logic core_clk,
    input logic sys_rst,
    input logic psel,
    input logic penable,
    input logic [11:0] paddr,
    input logic pready,
    input logic pslverr,
    input logic instr_last,
    input isa_mem_t mem_out,
    input isa_load_t pc_out,
    input isa_load_t sp_out,
    input logic status_load,
    input logic seq_busy,
    input logic master_irq_enable
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    logic mapped;
    logic push;
    assign mapped = paddr inside {`ISA_ADDR_ENABLE, `ISA_ADDR_LATCH,
        `ISA_ADDR_SELECT, `ISA_ADDR_STATUS};
    assign push = mem_out.req && mem_out.we;

    a_apb_one_wait:
        assert property (psel && !penable |=> !pready ##1 pready)
        else $error("apb answer not in second access cycle");
    a_unmapped_err:
        assert property (pready |-> pslverr == !mapped)
        else $error("slave error does not match address map");
    a_push_order:
        assert property ($rose(push) |-> ##1 (push
            && mem_out.addr == $past(mem_out.addr) - 16'd1) ##1 (push
            && mem_out.addr == $past(mem_out.addr) - 16'd1
            && sp_out.load && sp_out.value == mem_out.addr - 16'd1))
        else $error("stack push order or pointer wrong");
    a_master_off:
        assert property ($rose(push) |-> !master_irq_enable)
        else $error("master enable still set during accept");
    a_vector_load:
        assert property ($rose(push) |-> ##3 (mem_out.req && !mem_out.we
            && !mem_out.addr[0]) ##1 (mem_out.req && !mem_out.we
            && mem_out.addr == $past(mem_out.addr) + 16'd1)
            ##[1:2] pc_out.load)
        else $error("vector fetch or program counter load wrong");
    a_return_reads:
        assert property ($rose(mem_out.req) && !mem_out.we |->
            ##1 (mem_out.addr == $past(mem_out.addr) + 16'd1)
            ##1 (mem_out.addr == $past(mem_out.addr) + 16'd1)
            ##[1:2] pc_out.load ##1 (status_load && sp_out.load))
        else $error("return restore sequence wrong");
    a_busy_start:
        assert property ($rose(seq_busy) |->
            $past(instr_last) || $past(instr_last, 2))
        else $error("sequence started off an instruction end");
    a_pc_pulse:
        assert property (pc_out.load |=> !pc_out.load)
        else $error("program counter load longer than one cycle");
endmodule

bind isa_core isa_core_props chk_u (.core_clk, .sys_rst, .psel,
    .penable, .paddr, .pready, .pslverr, .instr_last, .mem_out, .pc_out,
    .sp_out, .status_load, .seq_busy, .master_irq_enable);

//--- isa_cpu_mem.sv
`timescale 1ns/100ps

module isa_cpu_mem
    import isa_pkg::*;
(
    input logic core_clk,
    input isa_mem_t mem_out,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:65535];

    initial
    begin
        mem_rdata = 8'h00;
        for (int i = 0; i < 16; i++)
        begin
            mem[16'hfffe - 16'(2 * i)] = 8'(i << 4);
            mem[16'hffff - 16'(2 * i)] = 8'h80 + 8'(i);
        end
    end

    // Idle data toggles so stale bytes never pass
    always @(posedge core_clk)
    begin
        if (mem_out.req && mem_out.we)
            mem[mem_out.addr] <= mem_out.wdata;
        if (mem_out.req && !mem_out.we)
            mem_rdata <= mem[mem_out.addr];
        else
            mem_rdata <= ~mem_rdata;
    end
endmodule

//--- isa_params.svh
// Contract
// R01 - Shared level latch is set only by the source the selector picks
// R02 - Requests from the unselected shared source are dropped, not kept
// R03 - Level 9 takes serial receive A, or sync serial when bit 7 set
// R04 - Level 13 takes output compare, or external input two when bit 3 set
// R05 - Level 14 takes external input three, or serial receive B if bit 2
// R06 - Level 15 takes external input four, or serial transmit B if bit 1
// R07 - Level 16 takes timer counter, or external input five when bit 0 set
// R08 - Software programs the selector before shared sources raise requests
// R09 - A set latch holds until accepted, reset, or software clear
// R10 - Acceptance takes 8 machine cycles, starting after current instruction
// R11 - Acceptance first clears the master interrupt enable
// R12 - Acceptance clears the latch of the accepted source
// R13 - Push status with enable, PC high, PC low; stack pointer minus 3
// R14 - Load PC from the vector table entry of the accepted source
// R15 - At most 38 clocks from latch set to start of acceptance
// R16 - Master enable low blocks every maskable request, even higher ones
// R17 - Software ends each service with its matching return instruction
// R18 - Either return restores PC, status and enable; stack pointer plus 3
// R19 - After acceptance PC low sits at SP+1 and PC high at SP+2
// R20 - Requests sampled in last instruction cycle, even right after return
// R21 - Only PC and status word are saved by hardware
// R22 - Master enable low overrides all individual enable flags
// R23 - Writing 0 clears a latch bit, writing 1 never sets it
// R24 - Non-maskable requests ignore master and individual enables
// R25 - Among pending requests the highest priority level wins
`ifndef ISA_PARAMS_SVH
`define ISA_PARAMS_SVH

`define ISA_IDX_ENABLE 8'h3a
`define ISA_IDX_LATCH 8'h3c
`define ISA_IDX_SELECT 8'h3e
`define ISA_IDX_STATUS 8'h40
`define ISA_ADDR_ENABLE 12'h0e8
`define ISA_ADDR_LATCH 12'h0f0
`define ISA_ADDR_SELECT 12'h0f8
`define ISA_ADDR_STATUS 12'h100

`define ISA_SELECT_RESET 8'h00
`define ISA_ENABLE_RESET 16'h0000
`define ISA_LATCH_RESET 16'h0000
`define ISA_SELECT_MASK 8'h8f

`define ISA_SEL_LEVEL9 7
`define ISA_SEL_LEVEL13 3
`define ISA_SEL_LEVEL14 2
`define ISA_SEL_LEVEL15 1
`define ISA_SEL_LEVEL16 0
`define ISA_BIT_MASTER_EN 0
`define ISA_BIT_NMI 3
`define ISA_FIRST_MASKABLE 4

`define ISA_ACCEPT_CYCLES 3'd7
`define ISA_RETURN_CYCLES 3'd5
`define ISA_MAX_LATENCY_CLKS 38
`define ISA_VECTOR_TOP 16'hfffe

`endif

//--- isa_pkg.sv
package isa_pkg;

    typedef enum logic [1:0] {
        ISA_IDLE = 2'b00,
        ISA_ACCEPT = 2'b01,
        ISA_RETURN = 2'b11
    } isa_state_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } isa_mem_t;

    typedef struct packed {
        logic load;
        logic [15:0] value;
    } isa_load_t;

endpackage
